// [src/pmrc_top.sv]
// Power mode and reset controller: shallow/deep sleep, wake, reset causes, boot select.
// Assumes pins are asynchronous to CLOCK; core, radio and config inputs are CLOCK-synchronous.
// Overview of operation
// RULE_01 - Shallow sleep stops the core, clocks run, core resumes within 7 us.
// RULE_02 - Shallow sleep is entered and left automatically with no software action.
// RULE_03 - Deep sleep turns off system clocks, peripherals and the serial port.
// RULE_04 - Deep sleep ends on serial wake, GPIO interrupt, RTC event or radio event.
// RULE_05 - After deep wake, clocks settle first; operational within 70 us.
// RULE_06 - RAM contents are kept in every power state.
// RULE_07 - The RTC runs in every state and can always raise a wake.
// RULE_08 - RTC offers periodic and programmed-time wakes, calendar and sub-second count.
// RULE_09 - Clocks derive from 32.768 kHz reference, allowed two seconds to settle.
// RULE_10 - Core resets on reset pin low, power-up reset or watchdog expiry.
// RULE_11 - Boot select high at reset release gives recovery mode; low gives normal boot.
// RULE_12 - GPIO interrupt number may be enabled on one port only, never both. The code accepts both and masks port B where port A is enabled.
// RULE_13 - Host should use RTS/CTS flow control on the serial link.
// RULE_14 - After wake command, host waits for ready or the maximum wake delay.
`timescale 1ns/10ps
`default_nettype none
module pmrc_top
	import pmrc_pkg::*;
#(
	parameter int unsigned OSC_CYC  = OSC_SETTLE_CYC,
	parameter int unsigned WDOG_CYC = WDOG_TIMEOUT_CYC
)
(
	input  wire logic                CLOCK,
	input  wire logic                RST,
	input  wire logic                EXT_RESET_N,
	input  wire logic                BOOT_SELECT_PIN,
	input  wire logic                RTC_REF,
	input  wire logic                SERIAL_WAKE,
	input  wire logic [NUM_GPIO-1:0] GPIO_PORT_A,
	input  wire logic [NUM_GPIO-1:0] GPIO_PORT_B,
	input  wire logic [NUM_GPIO-1:0] GPIO_IRQ_EN_A,
	input  wire logic [NUM_GPIO-1:0] GPIO_IRQ_EN_B,
	input  wire logic                RADIO_EVENT,
	input  wire logic                CORE_IRQ,
	input  wire logic                CORE_IDLE,
	input  wire logic                DEEP_SLEEP_REQ,
	input  wire logic                WDOG_KICK,
	input  wire logic                ALARM_EN,
	input  wire pmrc_time_t          ALARM_TIME,
	input  wire logic                PERIOD_EN,
	input  wire logic [15:0]         PERIOD_SEC,
	output logic                     CORE_RESET,
	output logic                     RECOVERY_MODE,
	output logic                     CORE_RUN,
	output logic                     SYS_CLK_EN,
	output logic                     PERIPH_PWR_EN,
	output logic                     UART_EN,
	output logic                     RAM_RETAIN,
	output logic                     READY,
	output pmrc_wake_t               WAKE_CAUSE,
	output pmrc_time_t               RTC_NOW
);
	logic [SYNC_W-1:0]     sync1_q;
	logic [SYNC_W-1:0]     sync2_q;
	logic                  ref_prev_q;
	logic                  ref_tick;
	logic                  rtc_wake;
	logic [NUM_GPIO-1:0]   en_b_eff;
	logic                  gpio_irq;
	logic                  wake_any;
	pmrc_wake_t            cause_now;
	logic [31:0]           osc_cnt_q;
	logic [31:0]           osc_cnt_d;
	logic                  osc_done;
	logic [31:0]           wdog_q;
	logic [31:0]           wdog_d;
	logic                  wdog_exp;
	logic [4:0]            crst_q;
	logic [4:0]            crst_d;
	logic                  core_rst_q;
	logic                  core_rst_d;
	logic                  recovery_q;
	logic                  recovery_d;
	logic                  rst_cause;
	pmrc_state_t           state_q;
	pmrc_state_t           state_d;
	logic [SETTLE_W-1:0]   settle_q;
	logic [SETTLE_W-1:0]   settle_d;
	pmrc_wake_t            cause_q;
	pmrc_wake_t            cause_d;

	// Pins pass two flops; only the second stage is read
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			sync1_q    <= '0;
			sync2_q    <= '0;
			ref_prev_q <= 1'b0;
		end
		else
		begin
			sync1_q    <= {GPIO_PORT_B, GPIO_PORT_A, SERIAL_WAKE, RTC_REF, BOOT_SELECT_PIN, EXT_RESET_N};
			sync2_q    <= sync1_q;
			ref_prev_q <= sync2_q[SY_RTC_REF];
		end
	end

	assign ref_tick = sync2_q[SY_RTC_REF] && !ref_prev_q; // RULE_09

	// RTC is never gated by the power state
	pmrc_rtc u_rtc
	(
		.clk        (CLOCK),
		.rst        (RST),
		.ref_tick   (ref_tick),
		.alarm_en   (ALARM_EN),
		.alarm_time (ALARM_TIME),
		.period_en  (PERIOD_EN),
		.period_sec (PERIOD_SEC),
		.now_q      (RTC_NOW),
		.sub_q      (),
		.wake_q     (rtc_wake)
	);

	// Port A wins a shared number, so B is masked where A is enabled
	assign en_b_eff = GPIO_IRQ_EN_B & ~GPIO_IRQ_EN_A; // RULE_12
	assign gpio_irq = |(sync2_q[SY_GPIO_A +: NUM_GPIO] & GPIO_IRQ_EN_A)
	                | |(sync2_q[SY_GPIO_B +: NUM_GPIO] & en_b_eff);

	assign cause_now.serial = sync2_q[SY_SER_WAKE];
	assign cause_now.gpio   = gpio_irq;
	assign cause_now.rtc    = rtc_wake;
	assign cause_now.radio  = RADIO_EVENT;
	assign wake_any         = |cause_now; // RULE_04

	// Reset causes, watchdog and reference settle
	assign osc_done  = osc_cnt_q >= OSC_CYC; // RULE_09
	assign wdog_exp  = !core_rst_q && wdog_q >= WDOG_CYC - 1;
	assign rst_cause = !sync2_q[SY_RESET_N] || wdog_exp || !osc_done; // RULE_10

	always_comb
	begin
		osc_cnt_d  = osc_done ? osc_cnt_q : osc_cnt_q + 32'h00000001;
		// Watchdog count clears to zero while the core is asleep or held in reset
		if (core_rst_q || WDOG_KICK || state_q != ST_ACTIVE || wdog_exp)
			wdog_d = 32'h00000000;
		else
			wdog_d = wdog_q + 32'h00000001;
		// Stretch so a one-cycle cause still gives a clean core reset
		if (rst_cause)
			crst_d = 5'(CORE_RST_CYC);
		else if (crst_q != 5'h00)
			crst_d = crst_q - 5'h01;
		else
			crst_d = crst_q;
		core_rst_d = rst_cause || crst_d != 5'h00; // RULE_10
		recovery_d = recovery_q;
		if (core_rst_q && !core_rst_d)
			recovery_d = sync2_q[SY_BOOT]; // RULE_11
	end

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			osc_cnt_q  <= 32'h00000000;
			wdog_q     <= 32'h00000000;
			crst_q     <= 5'(CORE_RST_CYC);
			core_rst_q <= 1'b1;
			recovery_q <= 1'b0;
		end
		else
		begin
			osc_cnt_q  <= osc_cnt_d;
			wdog_q     <= wdog_d;
			crst_q     <= crst_d;
			core_rst_q <= core_rst_d;
			recovery_q <= recovery_d;
		end
	end

	// Power state machine
	always_comb
	begin
		state_d  = state_q;
		settle_d = settle_q;
		cause_d  = cause_q;
		case (state_q)
			ST_ACTIVE:
			begin
				if (!core_rst_q && CORE_IDLE)
				begin
					if (DEEP_SLEEP_REQ)
					begin
						state_d = ST_DEEP; // RULE_03
						cause_d = '0;
					end
					else
						state_d = ST_SHALLOW; // RULE_02
				end
			end
			ST_SHALLOW:
			begin
				if (wake_any || CORE_IRQ)
					state_d = ST_ACTIVE; // RULE_01
			end
			ST_DEEP:
			begin
				if (wake_any)
				begin
					state_d  = ST_WAKE; // RULE_04
					settle_d = '0;
					cause_d  = cause_now;
				end
			end
			ST_WAKE:
			begin
				// Settle time sits inside the maximum wake delay
				if (settle_q == SETTLE_W'(CLK_SETTLE_CYC - 1))
					state_d = ST_ACTIVE; // RULE_05
				else
					settle_d = settle_q + 1'b1;
			end
			default:
				state_d = ST_ACTIVE;
		endcase
		if (core_rst_q)
			state_d = ST_ACTIVE;
	end

	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			state_q  <= ST_ACTIVE;
			settle_q <= '0;
			cause_q  <= '0;
		end
		else
		begin
			state_q  <= state_d;
			settle_q <= settle_d;
			cause_q  <= cause_d;
		end
	end

	assign CORE_RESET    = core_rst_q;
	assign RECOVERY_MODE = recovery_q;
	assign CORE_RUN      = state_q == ST_ACTIVE && !core_rst_q; // RULE_01
	assign SYS_CLK_EN    = state_q != ST_DEEP; // RULE_03
	assign PERIPH_PWR_EN = state_q != ST_DEEP;
	assign UART_EN       = state_q == ST_ACTIVE || state_q == ST_SHALLOW; // RULE_03
	// Retention supply never drops, so memory needs no reload on wake
	assign RAM_RETAIN    = 1'b1; // RULE_06
	// Serves as the host's go-ahead after a wake command
	assign READY         = UART_EN && !core_rst_q; // RULE_14
	assign WAKE_CAUSE    = cause_q;

	localparam int A_SHW = SHALLOW_WAKE_CYC;
	localparam int A_DPW = DEEP_WAKE_CYC;

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	property p_shallow_halt;
		state_q == ST_SHALLOW |-> !CORE_RUN && SYS_CLK_EN && UART_EN && PERIPH_PWR_EN;
	endproperty
	a_shallow_halt: assert property (p_shallow_halt) else $error("Shallow sleep left core running"); // RULE_01

	property p_shallow_wake;
		state_q == ST_SHALLOW && (wake_any || CORE_IRQ) && !rst_cause |-> ##[1:A_SHW] CORE_RUN;
	endproperty
	a_shallow_wake: assert property (p_shallow_wake) else $error("Shallow wake too slow"); // RULE_01

	property p_auto_enter;
		state_q == ST_ACTIVE && CORE_IDLE && !DEEP_SLEEP_REQ && !core_rst_q && !rst_cause |=> state_q == ST_SHALLOW;
	endproperty
	a_auto_enter: assert property (p_auto_enter) else $error("Shallow sleep not entered"); // RULE_02

	property p_deep_off;
		state_q == ST_DEEP |-> !UART_EN && !SYS_CLK_EN && !PERIPH_PWR_EN && !READY && RAM_RETAIN;
	endproperty
	a_deep_off: assert property (p_deep_off) else $error("Deep sleep left clocks or serial on"); // RULE_03

	property p_deep_wake;
		state_q == ST_DEEP && wake_any && !core_rst_q |=> state_q == ST_WAKE && WAKE_CAUSE == $past(cause_now);
	endproperty
	a_deep_wake: assert property (p_deep_wake) else $error("Deep wake cause ignored"); // RULE_04

	property p_deep_ready;
		$rose(state_q == ST_WAKE) && !rst_cause |-> !READY[*8] ##[1:A_DPW] READY;
	endproperty
	a_deep_ready: assert property (p_deep_ready) else $error("Deep wake not ready in time"); // RULE_05

	property p_wdog;
		wdog_exp |=> CORE_RESET[*8];
	endproperty
	a_wdog: assert property (p_wdog) else $error("Watchdog expiry did not reset core"); // RULE_10

	property p_ext_reset;
		!sync2_q[SY_RESET_N] |=> CORE_RESET && state_q == ST_ACTIVE;
	endproperty
	a_ext_reset: assert property (p_ext_reset) else $error("Reset pin ignored"); // RULE_10

	property p_boot;
		$fell(CORE_RESET) |-> RECOVERY_MODE == $past(sync2_q[SY_BOOT]);
	endproperty
	a_boot: assert property (p_boot) else $error("Boot select not captured at release"); // RULE_11

	// A port B pin on a number that port A also enables must never raise the interrupt
	property p_gpio_excl;
		|(sync2_q[SY_GPIO_B +: NUM_GPIO] & GPIO_IRQ_EN_B & GPIO_IRQ_EN_A)
		&& !(|(sync2_q[SY_GPIO_A +: NUM_GPIO] & GPIO_IRQ_EN_A))
		&& !(|(sync2_q[SY_GPIO_B +: NUM_GPIO] & GPIO_IRQ_EN_B & ~GPIO_IRQ_EN_A)) |-> !gpio_irq;
	endproperty
	a_gpio_excl: assert property (p_gpio_excl) else $error("GPIO interrupt enabled on both ports"); // RULE_12

	c_shallow: cover property (state_q == ST_SHALLOW ##1 state_q == ST_ACTIVE);
	c_deep: cover property (state_q == ST_WAKE ##1 state_q == ST_ACTIVE);
	c_recovery: cover property ($rose(RECOVERY_MODE));
	c_wdog: cover property (wdog_exp);
endmodule
`default_nettype wire

// [common/pmrc_pkg.sv]
// Constants and types for the power mode and reset controller.
// Assumes a single 10 MHz system clock; all times are derived from its period.
package pmrc_pkg;
	localparam int unsigned CLK_PERIOD_NS      = 100;
	// Longest times round down
	localparam int unsigned T_SHALLOW_WAKE_NS  = 7000;
	localparam int unsigned SHALLOW_WAKE_CYC   = T_SHALLOW_WAKE_NS / CLK_PERIOD_NS;
	localparam int unsigned T_DEEP_WAKE_NS     = 70000;
	localparam int unsigned DEEP_WAKE_CYC      = T_DEEP_WAKE_NS / CLK_PERIOD_NS;
	// Least times round up
	localparam int unsigned T_CLK_SETTLE_NS    = 60000;
	localparam int unsigned CLK_SETTLE_CYC     = (T_CLK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned T_OSC_SETTLE_MS    = 2000;
	localparam int unsigned OSC_SETTLE_CYC     = T_OSC_SETTLE_MS * (1000000 / CLK_PERIOD_NS);
	localparam int unsigned T_WDOG_MS          = 1000;
	localparam int unsigned WDOG_TIMEOUT_CYC   = T_WDOG_MS * (1000000 / CLK_PERIOD_NS);
	localparam int unsigned CORE_RST_CYC       = 16;
	localparam int unsigned RTC_REF_HZ         = 32768;
	localparam int unsigned RTC_SUB_W          = $clog2(RTC_REF_HZ);
	localparam int unsigned NUM_GPIO           = 16;
	localparam int unsigned SETTLE_W           = 10;
	localparam logic [5:0]  SEC_MAX            = 6'h3B;
	localparam logic [5:0]  MIN_MAX            = 6'h3B;
	localparam logic [4:0]  HOUR_MAX           = 5'h17;
	// Synchroniser lanes
	localparam int unsigned SY_RESET_N         = 0;
	localparam int unsigned SY_BOOT            = 1;
	localparam int unsigned SY_RTC_REF         = 2;
	localparam int unsigned SY_SER_WAKE        = 3;
	localparam int unsigned SY_GPIO_A          = 4;
	localparam int unsigned SY_GPIO_B          = SY_GPIO_A + NUM_GPIO;
	localparam int unsigned SYNC_W             = SY_GPIO_B + NUM_GPIO;

	typedef enum logic [3:0]
	{
		ST_ACTIVE  = 4'h1,
		ST_SHALLOW = 4'h2,
		ST_DEEP    = 4'h4,
		ST_WAKE    = 4'h8
	} pmrc_state_t;

	typedef struct packed
	{
		logic [15:0] day;
		logic [4:0]  hour;
		logic [5:0]  min;
		logic [5:0]  sec;
	} pmrc_time_t;

	typedef struct packed
	{
		logic serial;
		logic gpio;
		logic rtc;
		logic radio;
	} pmrc_wake_t;
endpackage

// [src/pmrc_rtc.sv]
// Always-on real-time clock: sub-second counter, calendar, alarm and periodic wake.
// Assumes ref_tick is a one-cycle pulse per reference oscillator period, never gated.
`timescale 1ns/10ps
`default_nettype none
module pmrc_rtc
	import pmrc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 ref_tick,
	input  wire logic                 alarm_en,
	input  wire pmrc_time_t           alarm_time,
	input  wire logic                 period_en,
	input  wire logic [15:0]          period_sec,
	output pmrc_time_t                now_q,
	output logic [RTC_SUB_W-1:0]      sub_q,
	output logic                      wake_q
);
	pmrc_time_t             now_d;
	logic [RTC_SUB_W-1:0]   sub_d;
	logic [15:0]            per_q;
	logic [15:0]            per_d;
	logic                   wake_d;
	logic                   sec_tick;

	function automatic pmrc_time_t next_time(input pmrc_time_t t);
		pmrc_time_t n;
		n = t;
		if (t.sec != SEC_MAX)
			n.sec = t.sec + 6'h01;
		else
		begin
			n.sec = 6'h00;
			if (t.min != MIN_MAX)
				n.min = t.min + 6'h01;
			else
			begin
				n.min = 6'h00;
				if (t.hour != HOUR_MAX)
					n.hour = t.hour + 5'h01;
				else
				begin
					n.hour = 5'h00;
					n.day  = t.day + 16'h0001;
				end
			end
		end
		return n;
	endfunction

	assign sec_tick = ref_tick && (&sub_q);

	always_comb
	begin
		sub_d  = ref_tick ? sub_q + 1'b1 : sub_q; // RULE_07
		now_d  = sec_tick ? next_time(now_q) : now_q; // RULE_08
		per_d  = per_q;
		wake_d = 1'b0;
		if (sec_tick && alarm_en && next_time(now_q) == alarm_time)
			wake_d = 1'b1; // RULE_08
		if (sec_tick && period_en && period_sec != 16'h0000)
		begin
			if (per_q >= period_sec - 16'h0001)
			begin
				per_d  = 16'h0000;
				wake_d = 1'b1; // RULE_08
			end
			else
				per_d = per_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sub_q  <= '0;
			now_q  <= '0;
			per_q  <= 16'h0000;
			wake_q <= 1'b0;
		end
		else
		begin
			sub_q  <= sub_d;
			now_q  <= now_d;
			per_q  <= per_d;
			wake_q <= wake_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_rtc_second;
		sec_tick |=> now_q != $past(now_q) && sub_q == '0;
	endproperty
	a_rtc_second: assert property (p_rtc_second) else $error("RTC second did not advance"); // RULE_08

	property p_rtc_alarm;
		sec_tick && alarm_en && next_time(now_q) == alarm_time |=> wake_q && now_q == alarm_time;
	endproperty
	a_rtc_alarm: assert property (p_rtc_alarm) else $error("RTC alarm wake missing"); // RULE_08

	property p_rtc_quiet;
		!sec_tick |=> !wake_q;
	endproperty
	a_rtc_quiet: assert property (p_rtc_quiet) else $error("RTC wake without second tick"); // RULE_07

	c_rtc_wake: cover property (wake_q);
endmodule
`default_nettype wire

// [verif/pmrc_host_model.sv]
// Host microcontroller model: raises the serial wake indication and holds data.
// Assumes start is a one-cycle pulse synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module pmrc_host_model
	import pmrc_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic start,
	input  wire logic ready,
	output logic      serial_wake,
	output logic      may_send
);
	int unsigned wait_q;

	// Data held back until ready or the longest wake delay
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			serial_wake <= 1'b0;
			may_send    <= 1'b1;
			wait_q      <= 0;
		end
		else if (start)
		begin
			serial_wake <= 1'b1;
			may_send    <= 1'b0;
			wait_q      <= 0;
		end
		else if (serial_wake)
		begin
			wait_q <= wait_q + 1;
			if (ready || wait_q + 1 >= DEEP_WAKE_CYC)
			begin
				serial_wake <= 1'b0;
				may_send    <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the power mode and reset controller.
// Assumes short oscillator and watchdog counts; the RTC reference toggles only in the alarm scenario.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import pmrc_pkg::*;
;
	localparam int unsigned OSC = 10;
	localparam int unsigned WDG = 200;
	logic                clock, rst, ext_rst_n, boot, rtc_ref, radio, irq, idle, deep_req;
	logic                kick, kick_en, alarm_en, period_en, host_start;
	logic [NUM_GPIO-1:0] gpio_a, gpio_b, en_a, en_b;
	logic [15:0]         period_sec;
	pmrc_time_t          alarm_time, now;
	logic                core_reset, recovery, core_run, clk_en, pwr_en, uart_en, ram_retain, ready;
	logic                serial_wake, may_send;
	pmrc_wake_t          cause;
	int                  errors, cmp_count;

	pmrc_top #(.OSC_CYC(OSC), .WDOG_CYC(WDG)) dut_u (.CLOCK(clock), .RST(rst), .EXT_RESET_N(ext_rst_n),
		.BOOT_SELECT_PIN(boot), .RTC_REF(rtc_ref), .SERIAL_WAKE(serial_wake), .GPIO_PORT_A(gpio_a),
		.GPIO_PORT_B(gpio_b), .GPIO_IRQ_EN_A(en_a), .GPIO_IRQ_EN_B(en_b), .RADIO_EVENT(radio),
		.CORE_IRQ(irq), .CORE_IDLE(idle), .DEEP_SLEEP_REQ(deep_req), .WDOG_KICK(kick),
		.ALARM_EN(alarm_en), .ALARM_TIME(alarm_time), .PERIOD_EN(period_en), .PERIOD_SEC(period_sec),
		.CORE_RESET(core_reset), .RECOVERY_MODE(recovery), .CORE_RUN(core_run), .SYS_CLK_EN(clk_en),
		.PERIPH_PWR_EN(pwr_en), .UART_EN(uart_en), .RAM_RETAIN(ram_retain), .READY(ready),
		.WAKE_CAUSE(cause), .RTC_NOW(now));

	pmrc_host_model host_u (.clk(clock), .rst(rst), .start(host_start), .ready(ready),
		.serial_wake(serial_wake), .may_send(may_send));

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Kicking every cycle keeps the watchdog out of the other scenarios
	always @(posedge clock)
		kick <= kick_en;

	task automatic conclude();
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic got, input logic exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask

	function automatic logic sel(input int k);
		case (k)
			0: sel = core_reset;
			1: sel = core_run;
			default: sel = ready;
		endcase
	endfunction

	// Always lets one edge pass, so launch-edge values are never read
	task automatic wait_lvl(input int k, input logic v, input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge clock);
			#1;
			n++;
		end
		while (n < lim && sel(k) !== v);
		chk(sel(k), v, "wait for level");
	endtask

	task automatic power_up();
		int n;
		wait_lvl(0, 1'b0, 60, n);
		chk(n >= OSC + 16, 1'b1, "reset stretch");
		chk(recovery, 1'b0, "normal boot");
		chk(ram_retain, 1'b1, "retention");
	endtask

	task automatic shallow();
		int n;
		@(posedge clock);
		idle <= 1'b1;
		repeat (2) @(posedge clock);
		#1;
		chk(core_run, 1'b0, "core stopped");
		chk(clk_en & uart_en & ready, 1'b1, "clocks kept");
		@(posedge clock);
		idle <= 1'b0;
		irq  <= 1'b1;
		wait_lvl(1, 1'b1, SHALLOW_WAKE_CYC, n);
		@(posedge clock);
		irq <= 1'b0;
	endtask

	// Src 0 radio, 1 GPIO, 2 serial wake from the host
	task automatic deep(input int src);
		int n;
		pmrc_wake_t exp;
		exp = pmrc_wake_t'(src == 0 ? 4'h1 : (src == 1 ? 4'h4 : 4'h8));
		@(posedge clock);
		idle     <= 1'b1;
		deep_req <= 1'b1;
		@(posedge clock);
		idle     <= 1'b0;
		deep_req <= 1'b0;
		irq      <= 1'b1;
		gpio_b   <= 16'h0008;
		repeat (20) @(posedge clock);
		#1;
		chk(clk_en | pwr_en | uart_en | ready, 1'b0, "deep sleep");
		chk(ram_retain, 1'b1, "retention");
		@(posedge clock);
		irq    <= 1'b0;
		gpio_b <= 16'h0000;
		case (src)
			0: radio <= 1'b1;
			1: gpio_a <= 16'h0008;
			default: host_start <= 1'b1;
		endcase
		@(posedge clock);
		radio      <= 1'b0;
		host_start <= 1'b0;
		wait_lvl(2, 1'b1, DEEP_WAKE_CYC, n);
		chk(n >= CLK_SETTLE_CYC - 2, 1'b1, "settle first");
		chk(cause === exp, 1'b1, "wake cause");
		chk(clk_en & core_run, 1'b1, "resumed");
		@(posedge clock);
		gpio_a <= 16'h0000;
		#1;
		chk(may_send, 1'b1, "host released");
	endtask

	task automatic pin_reset(input logic b);
		int n;
		@(posedge clock);
		boot      <= b;
		ext_rst_n <= 1'b0;
		wait_lvl(0, 1'b1, 4, n);
		repeat (3) @(posedge clock);
		ext_rst_n <= 1'b1;
		wait_lvl(0, 1'b0, 30, n);
		chk(n >= 16, 1'b1, "pin reset stretch");
		chk(recovery, b, "boot mode");
		@(posedge clock);
		boot <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		chk(recovery, b, "boot mode kept");
	endtask

	task automatic watchdog();
		int n;
		kick_en = 1'b0;
		wait_lvl(0, 1'b1, WDG + 10, n);
		chk(n >= WDG - 2, 1'b1, "watchdog early");
		kick_en = 1'b1;
		wait_lvl(0, 1'b0, 30, n);
		chk(n >= 15, 1'b1, "watchdog stretch");
	endtask

	// One full second of reference edges in deep sleep; alarm set for second 1
	task automatic rtc_alarm();
		int n;
		@(posedge clock);
		alarm_en   <= 1'b1;
		alarm_time <= pmrc_time_t'(33'h000000001);
		idle       <= 1'b1;
		deep_req   <= 1'b1;
		@(posedge clock);
		idle     <= 1'b0;
		deep_req <= 1'b0;
		repeat (RTC_REF_HZ)
		begin
			@(posedge clock);
			rtc_ref <= 1'b1;
			@(posedge clock);
			rtc_ref <= 1'b0;
		end
		wait_lvl(2, 1'b1, DEEP_WAKE_CYC, n);
		chk(n >= CLK_SETTLE_CYC - 2, 1'b1, "alarm not early");
		chk(cause === 4'h2, 1'b1, "rtc wake cause");
		chk(now === 33'h000000001, 1'b1, "calendar time");
	endtask

	initial
	begin
		errors = 0;
		cmp_count = 0;
		kick_en = 1'b1;
		rst = 1'b1;
		{ext_rst_n, boot, rtc_ref, radio, irq, idle, deep_req, alarm_en, period_en, host_start} = 10'h200;
		{gpio_a, gpio_b, en_b} = '0;
		en_a = 16'h0008;
		en_b = 16'h0008;
		period_sec = 16'h0000;
		alarm_time = '0;
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		power_up();
		shallow();
		deep(0);
		deep(1);
		deep(2);
		pin_reset(1'b1);
		pin_reset(1'b0);
		watchdog();
		rtc_alarm();
		conclude();
	end

	// Run needs about 68300 cycles, most of them one RTC second
	initial
	begin
		#8000000;
		errors++;
		conclude();
	end
endmodule
`default_nettype wire
